//--- second_aligned_strobe_out.sv
// seven second-aligned strobe outputs with an apb register file
`timescale 1ns/100ps
`include "strobe_defs.svh"
// Contract
// R1: seven independent strobes, selected by index 0 through 6, each with its own settings.
// R2: every strobe cycle is an active interval followed by a non-active interval.
// R3: the active interval begins on the top-of-second tick.
// R4: the non-active interval follows at once, at the level opposite the active one.
// R5: polarity 0 (reset) makes the active level low, polarity 1 makes it high.
// R6: enable 0 disables, 1 enables, and the strobe is enabled after reset.
// R7: active time is set in nanoseconds, 500 after reset, never below 10.
// R8: non-active time is set in nanoseconds, 500 after reset, never below 10.
// R9: a total over one second is kept, the non-active level holding to the next second.
// R10: software should make the two times total one second, else the output repeats oddly.
// R11: a strobe drives its pin only while the pin function selection gives it that pin.
// R12: a disabled strobe sits at its inactive level and resumes on the next second.
module second_aligned_strobe_out import strobe_pkg::*; (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // top-of-second pin from the time keeper
  input wire logic secondPulse,
  // pin function selection, one bit per strobe
  input wire logic [6:0] pinFunctionSelect,
  // strobe pins
  output logic [6:0] strobeOutput,
  output logic [6:0] strobeOutputEn
);
  logic secondTick;
  logic ctrlEnable [`SAS_CHAN_COUNT];
  logic ctrlPolarity [`SAS_CHAN_COUNT];
  word_t activeNs [`SAS_CHAN_COUNT];
  word_t inactiveNs [`SAS_CHAN_COUNT];
  logic [6:0] chanLevel;
  logic [6:0] chanActive;
  logic [6:0] chanRunning;
  word_t secondCount;
  logic setupPhase;
  logic accessPhase;
  logic writeAccess;
  logic mapped;
  logic [2:0] selChan;
  word_t readValue;

  // true when the address names field off of a valid strobe index
  function automatic logic is_chan_reg(input logic [31:0] a, input logic [3:0] off);
    return (a[31:7] == 25'h0) && (a[6:4] <= `SAS_CHAN_LAST) && (a[3:0] == off);
  endfunction

  function automatic logic is_mapped(input logic [31:0] a);
    return is_chan_reg(a, `SAS_OFF_CTRL) || is_chan_reg(a, `SAS_OFF_ACTIVE)
      || is_chan_reg(a, `SAS_OFF_INACTIVE) || (a == `SAS_OFF_STATUS)
      || (a == `SAS_OFF_SECONDS);
  endfunction

  assign setupPhase = psel && !penable;
  assign accessPhase = psel && penable;
  assign writeAccess = accessPhase && pwrite;
  assign mapped = is_mapped(paddr);
  assign selChan = paddr[6:4];
  // zero wait states: read data is prepared during the setup cycle
  assign pready = 1'b1;

  tick_sync u_tick (
    .sys_clk(sys_clk),
    .reset_n(reset_n),
    .rawTick(secondPulse),
    .secondTick(secondTick)
  );

  // control bits: enable and polarity
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < `SAS_CHAN_COUNT; i++) begin
        ctrlEnable[i] <= `SAS_RST_ENABLE; // R6
        ctrlPolarity[i] <= `SAS_RST_POLARITY; // R5
      end
    end else if (writeAccess && is_chan_reg(paddr, `SAS_OFF_CTRL)) begin
      ctrlEnable[selChan] <= pwdata[`SAS_CTRL_EN_BIT]; // R1 R6
      ctrlPolarity[selChan] <= pwdata[`SAS_CTRL_POL_BIT]; // R5
    end
  end

  // active durations, clamped on the way in rather than refused
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < `SAS_CHAN_COUNT; i++) begin
        activeNs[i] <= `SAS_RST_ACTIVE_NS; // R7
      end
    end else if (writeAccess && is_chan_reg(paddr, `SAS_OFF_ACTIVE)) begin
      activeNs[selChan] <= clamp_ns(pwdata); // R7
    end
  end

  // non-active durations; a sum above one second is accepted as is
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < `SAS_CHAN_COUNT; i++) begin
        inactiveNs[i] <= `SAS_RST_INACTIVE_NS; // R8
      end
    end else if (writeAccess && is_chan_reg(paddr, `SAS_OFF_INACTIVE)) begin
      inactiveNs[selChan] <= clamp_ns(pwdata); // R8 R9
    end
  end

  // seconds seen since reset, lets software check the time base is alive
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      secondCount <= 32'h0;
    end else if (secondTick) begin
      secondCount <= secondCount + 32'h1;
    end
  end

  always_comb begin
    readValue = 32'h0;
    if (is_chan_reg(paddr, `SAS_OFF_CTRL)) begin
      readValue[`SAS_CTRL_EN_BIT] = ctrlEnable[selChan];
      readValue[`SAS_CTRL_POL_BIT] = ctrlPolarity[selChan];
    end else if (is_chan_reg(paddr, `SAS_OFF_ACTIVE)) begin
      readValue = activeNs[selChan];
    end else if (is_chan_reg(paddr, `SAS_OFF_INACTIVE)) begin
      readValue = inactiveNs[selChan];
    end else if (paddr == `SAS_OFF_STATUS) begin
      readValue = {9'h0, chanRunning, 1'b0, chanActive, 1'b0, chanLevel};
    end else if (paddr == `SAS_OFF_SECONDS) begin
      readValue = secondCount;
    end
  end

  // read data and error are captured in the setup cycle, valid in access
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else if (setupPhase) begin
      prdata <= pwrite ? 32'h0 : readValue;
      pslverr <= !mapped;
    end else begin
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end
  end

  // pin drive: the selection is registered so the enable is glitch free
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      strobeOutputEn <= 7'h0;
    end else begin
      strobeOutputEn <= pinFunctionSelect; // R11
    end
  end

  assign strobeOutput = chanLevel;

  for (genvar g = 0; g < `SAS_CHAN_COUNT; g++) begin : g_chan
    phase_t chanPhase;

    strobe_channel u_chan ( // R1
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .secondTick(secondTick),
      .enable(ctrlEnable[g]),
      .polarity(ctrlPolarity[g]),
      .activeNs(activeNs[g]),
      .inactiveNs(inactiveNs[g]),
      .level(chanLevel[g]),
      .phase(chanPhase)
    );

    assign chanActive[g] = (chanPhase == PH_ACTIVE);
    assign chanRunning[g] = (chanPhase != PH_IDLE);

    a_active_floor: assert property (@(posedge sys_clk) disable iff (!reset_n) // R7
      activeNs[g] >= `SAS_MIN_NS && activeNs[g] <= `SAS_MAX_NS)
      else $error("active time outside its range");
    a_inactive_floor: assert property (@(posedge sys_clk) disable iff (!reset_n) // R8
      inactiveNs[g] >= `SAS_MIN_NS && inactiveNs[g] <= `SAS_MAX_NS)
      else $error("non-active time outside its range");
    a_pin_select_gate: assert property (@(posedge sys_clk) disable iff (!reset_n) // R11
      !pinFunctionSelect[g] |=> !strobeOutputEn[g])
      else $error("strobe drives a pin it was not given");
    a_enable_write: assert property (@(posedge sys_clk) disable iff (!reset_n) // R6
      writeAccess && is_chan_reg(paddr, `SAS_OFF_CTRL) && selChan == g
      |=> ctrlEnable[g] == $past(pwdata[`SAS_CTRL_EN_BIT])
        && ctrlPolarity[g] == $past(pwdata[`SAS_CTRL_POL_BIT]))
      else $error("control write not taken");
  end

  a_unmapped_error: assert property (@(posedge sys_clk) disable iff (!reset_n)
    setupPhase && !mapped |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not flagged");
endmodule

//--- strobe_defs.svh
// offsets, field positions, reset values and timing for the strobe block
`ifndef STROBE_DEFS_SVH
`define STROBE_DEFS_SVH

`define SAS_CHAN_COUNT 7
`define SAS_CHAN_LAST 3'h6

`define SAS_OFF_CTRL 4'h0
`define SAS_OFF_ACTIVE 4'h4
`define SAS_OFF_INACTIVE 4'h8
`define SAS_OFF_STATUS 32'h00000080
`define SAS_OFF_SECONDS 32'h00000084

`define SAS_CTRL_EN_BIT 0
`define SAS_CTRL_POL_BIT 1

`define SAS_RST_ENABLE 1'b1
`define SAS_RST_POLARITY 1'b0
`define SAS_RST_ACTIVE_NS 32'h000001f4
`define SAS_RST_INACTIVE_NS 32'h000001f4
`define SAS_MIN_NS 32'h0000000a
`define SAS_MAX_NS 32'h3b9ac9ff

`define SAS_CLK_PERIOD_NS 32'h00000064

`endif

//--- strobe_pkg.sv
// types and shared arithmetic for the strobe block
package strobe_pkg;
  `include "strobe_defs.svh"

  typedef logic [31:0] word_t;

  // gray along idle -> active -> inactive -> active
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_ACTIVE = 2'b01,
    PH_INACTIVE = 2'b11
  } phase_t;

  // rounds up so a programmed time is never shortened
  function automatic word_t ns_to_cycles(input word_t ns);
    word_t c;
    c = (ns + `SAS_CLK_PERIOD_NS - 32'h1) / `SAS_CLK_PERIOD_NS;
    if (c == 32'h0) begin
      c = 32'h1;
    end
    return c;
  endfunction

  function automatic word_t clamp_ns(input word_t v);
    word_t r;
    r = v;
    if (v < `SAS_MIN_NS) begin
      r = `SAS_MIN_NS;
    end else if (v > `SAS_MAX_NS) begin
      r = `SAS_MAX_NS;
    end
    return r;
  endfunction
endpackage

//--- tick_sync.sv
// synchroniser and rising-edge detector for the top-of-second pin
`timescale 1ns/100ps
module tick_sync (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // pin side
  input wire logic rawTick,
  // one-cycle pulse on each accepted rising edge
  output logic secondTick
);
  logic syncA;
  logic syncB;
  logic syncC;
  logic accepted;

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      syncA <= 1'b0;
      syncB <= 1'b0;
      syncC <= 1'b0;
    end else begin
      syncA <= rawTick;
      syncB <= syncA;
      syncC <= syncB;
    end
  end

  // a level counts only once the last two stages agree
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      accepted <= 1'b0;
      secondTick <= 1'b0;
    end else begin
      secondTick <= (syncB == syncC) && syncC && !accepted;
      if (syncB == syncC) begin
        accepted <= syncC;
      end
    end
  end

  a_tick_single_pulse: assert property (@(posedge sys_clk) disable iff (!reset_n)
    secondTick |=> !secondTick) else $error("second tick longer than one cycle"); // R3
endmodule

//--- strobe_channel.sv
// one strobe generator: active then non-active interval, restarted each second
`timescale 1ns/100ps
module strobe_channel import strobe_pkg::*; (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // time base
  input wire logic secondTick,
  // settings
  input wire logic enable,
  input wire logic polarity,
  input wire word_t activeNs,
  input wire word_t inactiveNs,
  // state
  output logic level,
  output phase_t phase
);
  word_t count;
  phase_t next_phase;
  word_t next_count;

  always_comb begin
    next_phase = phase;
    next_count = count;
    if (!enable) begin
      next_phase = PH_IDLE; // R12
      next_count = 32'h0;
    end else if (secondTick) begin
      // a tick wins whenever the strobe is enabled, so an overlong setting is cut at the second
      next_phase = PH_ACTIVE; // R3 R9
      next_count = ns_to_cycles(activeNs); // R7
    end else begin
      unique case (phase)
        PH_IDLE: begin
          next_phase = PH_IDLE; // R12
        end
        PH_ACTIVE: begin
          if (count == 32'h1) begin
            next_phase = PH_INACTIVE; // R2 R4
            next_count = ns_to_cycles(inactiveNs); // R8
          end else begin
            next_count = count - 32'h1;
          end
        end
        PH_INACTIVE: begin
          if (count == 32'h1) begin
            // only reached when the total falls short of a second
            next_phase = PH_ACTIVE; // R10
            next_count = ns_to_cycles(activeNs);
          end else begin
            next_count = count - 32'h1;
          end
        end
        default: begin
          next_phase = PH_IDLE;
          next_count = 32'h0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      phase <= PH_IDLE;
      count <= 32'h0;
    end else begin
      phase <= next_phase;
      count <= next_count;
    end
  end

  // level tracks the phase it is entering, so it is a flop output
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      level <= 1'b1;
    end else begin
      level <= (next_phase == PH_ACTIVE) ? polarity : !polarity; // R4 R5
    end
  end

  a_tick_starts_active: assert property (@(posedge sys_clk) disable iff (!reset_n)
    enable && secondTick |=> phase == PH_ACTIVE && level == $past(polarity)) // R3
    else $error("strobe did not start on the second");
  a_active_ends_inactive: assert property (@(posedge sys_clk) disable iff (!reset_n)
    enable && !secondTick && phase == PH_ACTIVE && count == 32'h1
    |=> phase == PH_INACTIVE && level == !$past(polarity)) // R4
    else $error("non-active interval did not follow");
  a_disabled_idle: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !enable ##1 !enable |-> phase == PH_IDLE && level == !$past(polarity)) // R12
    else $error("disabled strobe not at inactive level");
  a_count_running: assert property (@(posedge sys_clk) disable iff (!reset_n)
    phase != PH_IDLE |-> count != 32'h0) // R2
    else $error("running interval with empty count");
endmodule

//--- strobe_sink.sv
// far-side equipment: sees the shared strobe pins as wire levels
`timescale 1ns/100ps
module strobe_sink (
  // strobe pins from the device
  input wire logic [6:0] strobeOutput,
  input wire logic [6:0] strobeOutputEn,
  // levels as seen on the wires
  output logic [6:0] pinLevel
);
  // a released pin floats up to the pull-up of the receiving equipment
  always_comb begin
    for (int i = 0; i < 7; i++) begin
      pinLevel[i] = strobeOutputEn[i] ? strobeOutput[i] : 1'b1;
    end
  end
endmodule

//--- second_aligned_strobe_out_bench.sv
// self-checking bench for the second-aligned strobe block
`timescale 1ns/100ps
module second_aligned_strobe_out_bench import strobe_pkg::*;;
  logic sys_clk, reset_n, psel, penable, pwrite, secondPulse, pready, pslverr;
  word_t paddr, pwdata, prdata;
  logic [6:0] pinFunctionSelect, strobeOutput, strobeOutputEn, pinLevel, selSeen, expLvl;
  logic [7:0] hist;
  int miscompares, testsRun, cycles, seed, tickCount;
  int en[7], pol[7], actNs[7], inaNs[7], ph[7], rem[7];
  second_aligned_strobe_out DUT (.sys_clk, .reset_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .secondPulse, .pinFunctionSelect,
    .strobeOutput, .strobeOutputEn);
  strobe_sink PARTNER (.strobeOutput, .strobeOutputEn, .pinLevel);
  task automatic close_out;
    if (miscompares == 0 && testsRun > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic cmp_word(input word_t got, input word_t exp, input string what);
    testsRun++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic cmp_pins(input logic [6:0] got, input logic [6:0] exp, input string what);
    testsRun++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  function automatic int cyc(input int ns);
    return (ns + 99) / 100;
  endfunction
  function automatic word_t exp_read(input word_t a, output logic err);
    err = 1'b0;
    if (a == 32'h84) return tickCount;
    if (a == 32'h80) return 32'h0;
    if (a < 32'h70 && a[3:0] == 4'h0) return {30'h0, pol[a[6:4]][0], en[a[6:4]][0]};
    if (a < 32'h70 && a[3:0] == 4'h4) return actNs[a[6:4]];
    if (a < 32'h70 && a[3:0] == 4'h8) return inaNs[a[6:4]];
    err = 1'b1;
    return 32'h0;
  endfunction
  function automatic void model_write(input word_t a, input word_t d);
    word_t v;
    v = d < 32'ha ? 32'ha : (d > 32'h3b9ac9ff ? 32'h3b9ac9ff : d);
    if (a < 32'h70 && a[3:0] == 4'h0) begin
      en[a[6:4]] = d[0];
      pol[a[6:4]] = d[1];
    end
    if (a < 32'h70 && a[3:0] == 4'h4) actNs[a[6:4]] = int'(v);
    if (a < 32'h70 && a[3:0] == 4'h8) inaNs[a[6:4]] = int'(v);
  endfunction
  // steps on the design's edge: channels use the settings from before the edge
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      hist = 8'h00;
      selSeen = 7'h00;
      expLvl = 7'h7f;
      for (int i = 0; i < 7; i++) begin
        en[i] = 1;
        pol[i] = 0;
        actNs[i] = 500;
        inaNs[i] = 500;
        ph[i] = 0;
      end
    end else begin
      hist = {hist[6:0], secondPulse};
      selSeen = pinFunctionSelect;
      if (hist[4] && !hist[5]) tickCount++;
      for (int i = 0; i < 7; i++) begin
        if (en[i] == 0) begin
          ph[i] = 0;
        end else if (hist[4] && !hist[5]) begin
          ph[i] = 1;
          rem[i] = cyc(actNs[i]);
        end else if (ph[i] != 0) begin
          rem[i]--;
          if (rem[i] == 0) begin
            ph[i] = 3 - ph[i];
            rem[i] = cyc(ph[i] == 1 ? actNs[i] : inaNs[i]);
          end
        end
        expLvl[i] = (ph[i] == 1) ? pol[i][0] : !pol[i][0];
      end
      if (psel && penable && pready && pwrite) model_write(paddr, pwdata);
    end
  end
  always @(negedge sys_clk) begin
    if (reset_n) begin
      cmp_pins(strobeOutput, expLvl, "levels");
      cmp_pins(strobeOutputEn, selSeen, "pin enables");
      cmp_pins(pinLevel, expLvl | ~selSeen, "wire levels");
    end
  end
  task automatic apb(input logic wr, input word_t a, input word_t d,
                     output word_t rd, output logic err);
    int n;
    n = 0;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rw(input logic wr, input word_t a, input word_t d);
    word_t rd, ex;
    logic er, ee;
    apb(wr, a, d, rd, er);
    ex = exp_read(a, ee);
    cmp_word({31'h0, er}, {31'h0, ee}, "error flag");
    if (!wr && a != 32'h80) cmp_word(rd, ex, "read data");
  endtask
  task automatic tick_pulse(input int lowCycles);
    @(posedge sys_clk);
    secondPulse <= 1'b1;
    repeat (4) @(posedge sys_clk);
    secondPulse <= 1'b0;
    repeat (lowCycles) @(posedge sys_clk);
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  // a hang is cut short well past the expected run length
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 30000) begin
      miscompares++;
      close_out();
    end
  end
  initial begin
    seed = 32'he0df;
    {reset_n, psel, penable, pwrite, secondPulse} = 5'h0;
    {paddr, pwdata} = 64'h0;
    pinFunctionSelect = 7'h7f;
    repeat (12) @(posedge sys_clk);
    reset_n <= 1'b1;
    for (int a = 0; a < 32'h94; a += 4) begin
      rw(1'b0, a, 32'h0);
    end
    rw(1'b1, 32'h7c, 32'h5);
    rw(1'b1, 32'h84, 32'h7);
    rw(1'b0, 32'h84, 32'h0);
    for (int c = 0; c < 7; c++) begin
      rw(1'b1, c * 16 + 4, 32'h3);
      rw(1'b0, c * 16 + 4, 32'h0);
      rw(1'b1, c * 16 + 8, 32'hffffffff);
      rw(1'b0, c * 16 + 8, 32'h0);
    end
    // short totals are programmed on purpose so the channels repeat between ticks
    for (int r = 0; r < 7; r++) begin
      for (int c = 0; c < 7; c++) begin
        rw(1'b1, c * 16, word_t'($random(seed) & 3));
        rw(1'b1, c * 16 + 4, $unsigned($random(seed)) % 1500);
        rw(1'b1, c * 16 + 8, $unsigned($random(seed)) % 1500);
      end
      rw(1'b1, r * 16 + 8, 32'h3b9aca00);
      pinFunctionSelect <= 7'($random(seed));
      tick_pulse(40);
      rw(1'b1, r * 16, 32'h2);
      tick_pulse(20);
      rw(1'b1, r * 16, 32'h3);
      tick_pulse(60);
      rw(1'b0, r * 16, 32'h0);
    end
    rw(1'b0, 32'h84, 32'h0);
    close_out();
  end
endmodule
